// ### design/pfbu_defs.svh
// Register offsets, field positions and reset values of the predicted flag branch unit
`ifndef PFBU_DEFS_SVH
`define PFBU_DEFS_SVH

// Register byte offsets on the APB window
`define PFBU_OFF_CTRL 8'h00
`define PFBU_OFF_STATUS 8'h04
`define PFBU_OFF_MASK 8'h08
`define PFBU_OFF_LAST 8'h0C
`define PFBU_OFF_SPC_LO 8'h10
`define PFBU_OFF_SPC_HI 8'h14
`define PFBU_OFF_SNPC_LO 8'h18
`define PFBU_OFF_SNPC_HI 8'h1C
`define PFBU_OFF_COUNT 8'h20

// Control register fields
`define PFBU_CTRL_TTE 0
`define PFBU_CTRL_DEPTH_LO 4
`define PFBU_CTRL_DEPTH_HI 6

// Status and mask bit positions
`define PFBU_EV_TAKEN 0
`define PFBU_EV_ILLEGAL 1
`define PFBU_EV_XTRAP 2
`define PFBU_EV_MISPRED 3

// Instruction word fields
`define PFBU_F_OP_HI 31
`define PFBU_F_OP_LO 30
`define PFBU_F_ANNUL 29
`define PFBU_F_COND_HI 28
`define PFBU_F_COND_LO 25
`define PFBU_F_SUB_HI 24
`define PFBU_F_SUB_LO 22
`define PFBU_F_CSH 21
`define PFBU_F_CSL 20
`define PFBU_F_PRED 19
`define PFBU_F_OFS_HI 18

// Encodings
`define PFBU_OP_BRANCH 2'h0
`define PFBU_SUB_FLAG 3'h1
`define PFBU_COND_NEVER 4'h0
`define PFBU_COND_ALWAYS 4'h8

// Reset values and build options
`define PFBU_RST_CTRL 32'h00000000
`define PFBU_RST_MASK 4'h0
`define PFBU_TRAP_FEATURE 1'b1

`endif

// ### design/pfbu_pkg.sv
// Types shared by the predicted flag branch unit
package pfbu_pkg;
  typedef logic [63:0] pfbu_addr_t;
  typedef logic [2:0] pfbu_depth_t;
  typedef enum logic [2:0] {OUT_NONE, OUT_TAKEN, OUT_NOT_TAKEN, OUT_ILLEGAL, OUT_XTRAP} pfbu_outcome_t;
endpackage

// ### design/pfbu_trap_save_mem.sv
// Per-depth store of saved trap PC and saved trap next PC
`timescale 1ns/10ps
module pfbu_trap_save_mem (
  input wire logic clk, // Core clock
  input wire logic rstN, // Synchronised reset, active low
  input wire logic wrEn, // Write strobe
  input wire pfbu_pkg::pfbu_depth_t wrIdx, // Write depth
  input wire pfbu_pkg::pfbu_addr_t wrPc, // Branch address
  input wire pfbu_pkg::pfbu_addr_t wrNpc, // Pre-branch next PC
  input wire pfbu_pkg::pfbu_depth_t rdIdx, // Read depth
  output pfbu_pkg::pfbu_addr_t rdPc_r, // Registered saved PC
  output pfbu_pkg::pfbu_addr_t rdNpc_r // Registered saved next PC
);
  pfbu_pkg::pfbu_addr_t pcMem [0:7];
  pfbu_pkg::pfbu_addr_t npcMem [0:7];

  // Array left unreset, it is only meaningful once a trap wrote it
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      pcMem[wrIdx] <= wrPc;
      npcMem[wrIdx] <= wrNpc;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rdPc_r <= 64'h0000000000000000;
      rdNpc_r <= 64'h0000000000000000;
    end
    else
    begin
      rdPc_r <= pcMem[rdIdx];
      rdNpc_r <= npcMem[rdIdx];
    end
  end
endmodule

// ### design/pfbu_branch_unit.sv
// Predicted flag branch decode and resolution with APB control and status
//
// Contract
// - The branch is recognised by format subcode 1 under the branch primary opcode.
// - Code-select 00 tests the word flags and code-select high with low clear tests the wide flags.
// - A set code_select_low bit is reserved and raises the illegal-opcode trap instead of branching.
// - Selectors 1001/0001, 1110/0110 and 1111/0111 test zero, negative and overflow clear/set.
// - Selectors 1010/0010 and 1011/0011 are the signed greater and greater-or-equal tests and complements.
// - Selectors 1100/0100 and 1101/0101 are the unsigned greater and carry-clear tests and complements.
// - The target is the branch PC plus four times the sign-extended 19-bit word offset, as a delayed transfer.
// - The always_branch always transfers and annuls the delay slot exactly when the annul bit is 1.
// - The never_branch never transfers and annuls the delay slot exactly when the annul bit is 1.
// - The never_branch target may be offered as a prefetch hint without touching architectural state.
// - A true conditional branch is taken and its delay slot always executes.
// - A false conditional branch with annul bit 1 is not taken and squashes the delay slot.
// - The prediction bit is only a hint and never changes the outcome.
// - With the feature present and transfer_trap_enable 1, a would-be transfer raises the transfer trap.
// - A transfer trap saves the branch PC and the pre-branch next PC at the current trap depth.
// - The never_branch never raises the transfer trap.
`timescale 1ns/10ps
`include "pfbu_defs.svh"
module pfbu_branch_unit (
  input wire logic ref_clk, // Core clock, 25 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [31:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped offset
  output logic irq, // Level interrupt
  input wire logic instrValid, // Decode slot holds an instruction
  input wire logic [31:0] instrWord, // Instruction word
  input wire pfbu_pkg::pfbu_addr_t instrPc, // Address of the instruction
  input wire pfbu_pkg::pfbu_addr_t preNextPc, // Next fetch PC before the branch
  input wire logic [3:0] wordFlags, // 32-bit flags {N,Z,V,C}
  input wire logic [3:0] wideFlags, // 64-bit flags {N,Z,V,C}
  output logic resolveValid, // Outcome valid, one cycle
  output logic transferTaken, // Delayed transfer to targetPc
  output pfbu_pkg::pfbu_addr_t targetPc, // Transfer target
  output logic annulSlot, // Squash the delay-slot instruction
  output logic illegalTrap, // Illegal-opcode trap
  output logic transferTrap, // Transfer trap instead of transfer
  output logic prefetchValid, // Prefetch hint strobe
  output pfbu_pkg::pfbu_addr_t prefetchPc, // Prefetch hint address
  output logic predictTaken // Prediction bit passed as a hint
);
  logic rstMeta_r;
  logic rstN;
  logic [31:0] ctrl_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [31:0] count_r;
  pfbu_pkg::pfbu_outcome_t last_r;
  pfbu_pkg::pfbu_outcome_t outcomeNxt;
  pfbu_pkg::pfbu_addr_t savedPc;
  pfbu_pkg::pfbu_addr_t savedNpc;

  // Condition test on {N,Z,V,C}; bit 3 of the selector inverts the base test
  function automatic logic evalCond(input logic [3:0] cond, input logic [3:0] f);
    logic n;
    logic z;
    logic v;
    logic c;
    logic base;
    n = f[3];
    z = f[2];
    v = f[1];
    c = f[0];
    case (cond[2:0])
      3'h0: base = 1'b0;
      3'h1: base = z;
      3'h2: base = z | (n ^ v);
      3'h3: base = n ^ v;
      3'h4: base = c | z;
      3'h5: base = c;
      3'h6: base = n;
      default: base = v;
    endcase
    return cond[3] ^ base;
  endfunction

  // Byte-lane merge for APB writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reset released through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // Instruction field decode
  wire logic [3:0] cond = instrWord[`PFBU_F_COND_HI:`PFBU_F_COND_LO];
  wire logic annulBit = instrWord[`PFBU_F_ANNUL];
  wire logic codeSelectHigh = instrWord[`PFBU_F_CSH];
  wire logic codeSelectLow = instrWord[`PFBU_F_CSL];
  wire logic predBit = instrWord[`PFBU_F_PRED];
  wire logic [18:0] wordOffsetField = instrWord[`PFBU_F_OFS_HI:0];
  wire logic isFmt = instrValid && (instrWord[`PFBU_F_OP_HI:`PFBU_F_OP_LO] == `PFBU_OP_BRANCH)
    && (instrWord[`PFBU_F_SUB_HI:`PFBU_F_SUB_LO] == `PFBU_SUB_FLAG);
  wire logic isAlways = (cond == `PFBU_COND_ALWAYS);
  wire logic isNever = (cond == `PFBU_COND_NEVER);
  wire logic isUncond = isAlways || isNever;

  // Flag set choice and branch resolution
  wire logic [3:0] selFlags = codeSelectHigh ? wideFlags : wordFlags;
  wire logic condTrue = evalCond(cond, selFlags);
  wire logic legal = isFmt && !codeSelectLow;
  wire logic illegalNxt = isFmt && codeSelectLow;
  wire logic trapEnable = `PFBU_TRAP_FEATURE & ctrl_r[`PFBU_CTRL_TTE];
  wire logic wouldTransfer = legal && condTrue && !isNever;
  wire logic xtrapNxt = wouldTransfer && trapEnable;
  wire logic takenNxt = wouldTransfer && !trapEnable;
  // Unconditional forms follow the annul bit; conditional ones annul only when false
  wire logic annulNxt = legal && !xtrapNxt && annulBit && (isUncond || !condTrue);
  // Offset sign-extended and scaled to bytes
  wire pfbu_pkg::pfbu_addr_t byteOffset = {{43{wordOffsetField[18]}}, wordOffsetField, 2'b00};
  wire pfbu_pkg::pfbu_addr_t targetNxt = instrPc + byteOffset;
  wire logic prefetchNxt = legal && isNever;
  // Hint compared only for statistics, never fed into the outcome
  wire logic mispredNxt = legal && !isUncond && (predBit != condTrue);
  wire pfbu_pkg::pfbu_depth_t trapDepth = ctrl_r[`PFBU_CTRL_DEPTH_HI:`PFBU_CTRL_DEPTH_LO];

  // Outcome code for the last-outcome register
  always_comb
  begin
    if (illegalNxt)
    begin
      outcomeNxt = pfbu_pkg::OUT_ILLEGAL;
    end
    else if (xtrapNxt)
    begin
      outcomeNxt = pfbu_pkg::OUT_XTRAP;
    end
    else if (takenNxt)
    begin
      outcomeNxt = pfbu_pkg::OUT_TAKEN;
    end
    else if (legal)
    begin
      outcomeNxt = pfbu_pkg::OUT_NOT_TAKEN;
    end
    else
    begin
      outcomeNxt = pfbu_pkg::OUT_NONE;
    end
  end

  // Registered resolution outputs, one cycle after the instruction
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      resolveValid <= 1'b0;
      transferTaken <= 1'b0;
      targetPc <= 64'h0000000000000000;
      annulSlot <= 1'b0;
      illegalTrap <= 1'b0;
      transferTrap <= 1'b0;
      prefetchValid <= 1'b0;
      prefetchPc <= 64'h0000000000000000;
      predictTaken <= 1'b0;
    end
    else
    begin
      resolveValid <= isFmt;
      transferTaken <= takenNxt;
      targetPc <= targetNxt;
      annulSlot <= annulNxt;
      illegalTrap <= illegalNxt;
      transferTrap <= xtrapNxt;
      prefetchValid <= prefetchNxt;
      prefetchPc <= targetNxt;
      predictTaken <= legal && predBit;
    end
  end

  // Saved trap state lives in its own store, indexed by trap depth
  pfbu_trap_save_mem saveMem (
    .clk(ref_clk),
    .rstN(rstN),
    .wrEn(xtrapNxt),
    .wrIdx(trapDepth),
    .wrPc(instrPc),
    .wrNpc(preNextPc),
    .rdIdx(trapDepth),
    .rdPc_r(savedPc),
    .rdNpc_r(savedNpc)
  );

  // APB decode; zero wait states so pready is constant high
  wire logic apbWrite = psel && penable && pwrite;
  wire logic [7:0] regOff = paddr[7:0];
  wire logic offOk = (paddr[31:8] == 24'h000000) && (regOff <= `PFBU_OFF_COUNT) && (regOff[1:0] == 2'h0);
  wire logic wrCtrl = apbWrite && offOk && (regOff == `PFBU_OFF_CTRL);
  wire logic wrStatus = apbWrite && offOk && (regOff == `PFBU_OFF_STATUS);
  wire logic wrMask = apbWrite && offOk && (regOff == `PFBU_OFF_MASK);
  wire logic [31:0] stClr = wrStatus ? laneMerge(32'h00000000, pwdata, pstrb) : 32'h00000000;
  // Merged mask word; only the low four bits are kept
  wire logic [31:0] maskMerged = laneMerge({28'h0000000, mask_r}, pwdata, pstrb);
  wire logic [3:0] events = {mispredNxt, xtrapNxt, illegalNxt, takenNxt};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !offOk;
  assign irq = |(status_r & mask_r);

  // Read mux
  always_comb
  begin
    if (!offOk)
    begin
      prdata = 32'h00000000;
    end
    else if (regOff == `PFBU_OFF_CTRL)
    begin
      prdata = ctrl_r;
    end
    else if (regOff == `PFBU_OFF_STATUS)
    begin
      prdata = {28'h0000000, status_r};
    end
    else if (regOff == `PFBU_OFF_MASK)
    begin
      prdata = {28'h0000000, mask_r};
    end
    else if (regOff == `PFBU_OFF_LAST)
    begin
      prdata = {27'h0, `PFBU_TRAP_FEATURE, 1'b0, last_r};
    end
    else if (regOff == `PFBU_OFF_SPC_LO)
    begin
      prdata = savedPc[31:0];
    end
    else if (regOff == `PFBU_OFF_SPC_HI)
    begin
      prdata = savedPc[63:32];
    end
    else if (regOff == `PFBU_OFF_SNPC_LO)
    begin
      prdata = savedNpc[31:0];
    end
    else if (regOff == `PFBU_OFF_SNPC_HI)
    begin
      prdata = savedNpc[63:32];
    end
    else
    begin
      prdata = count_r;
    end
  end

  // Control and mask; only defined control bits are kept
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_r <= `PFBU_RST_CTRL;
      mask_r <= `PFBU_RST_MASK;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrl_r <= laneMerge(ctrl_r, pwdata, pstrb) & 32'h00000071;
      end
      if (wrMask)
      begin
        mask_r <= maskMerged[3:0];
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      status_r <= 4'h0;
      last_r <= pfbu_pkg::OUT_NONE;
      count_r <= 32'h00000000;
    end
    else
    begin
      status_r <= (status_r & ~stClr[3:0]) | events;
      if (isFmt)
      begin
        last_r <= outcomeNxt;
        count_r <= count_r + 32'h00000001;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  AST_ILLEGAL_CODE: assert property (isFmt && codeSelectLow |=> illegalTrap && !transferTaken && !transferTrap)
    else $error("reserved code select did not trap");
  AST_NOT_FMT: assert property (instrValid && instrWord[24:22] != 3'h1 |=> !resolveValid && !transferTaken)
    else $error("other branch format resolved");
  AST_WIDE_FLAGS: assert property (legal && codeSelectHigh && cond == 4'h1 && !wideFlags[2] |=>
    !transferTaken && !transferTrap)
    else $error("wide flag set not used");
  AST_WORD_ZERO: assert property (legal && !codeSelectHigh && cond == 4'h9 && !wordFlags[2] && !trapEnable |=>
    transferTaken)
    else $error("not-zero test failed");
  AST_SIGNED_GT: assert property (legal && !codeSelectHigh && cond == 4'hA && (wordFlags[3] ^ wordFlags[1]) |=>
    !transferTaken)
    else $error("signed greater taken wrongly");
  AST_UNSIGNED_GT: assert property (legal && !codeSelectHigh && cond == 4'hC && wordFlags[0] == 1'b0 &&
    wordFlags[2] == 1'b0 && !trapEnable |=> transferTaken)
    else $error("unsigned greater not taken");
  AST_TARGET: assert property (transferTaken |-> targetPc == $past(instrPc) +
    {{43{$past(instrWord[18])}}, $past(instrWord[18:0]), 2'b00})
    else $error("wrong branch target");
  AST_ALWAYS: assert property (legal && isAlways && !trapEnable |=> transferTaken && annulSlot == $past(annulBit))
    else $error("always branch mishandled");
  AST_NEVER: assert property (legal && isNever |=> !transferTaken && !transferTrap && prefetchValid &&
    annulSlot == $past(annulBit))
    else $error("never branch mishandled");
  AST_TAKEN_SLOT: assert property (legal && !isUncond && condTrue && !trapEnable |=> transferTaken && !annulSlot)
    else $error("taken conditional annulled slot");
  AST_FALSE_ANNUL: assert property (legal && !isUncond && !condTrue |=> !transferTaken && annulSlot == $past(annulBit))
    else $error("false conditional slot handling wrong");
  AST_XTRAP: assert property (legal && isAlways && trapEnable |=> transferTrap && !transferTaken && !annulSlot)
    else $error("transfer trap not raised");
  AST_SAVE: assert property (xtrapNxt && trapDepth == ctrl_r[6:4] ##1 $stable(ctrl_r[6:4]) |=>
    savedPc == $past(instrPc, 2) && savedNpc == $past(preNextPc, 2))
    else $error("trap state not saved");
  AST_IRQ_STICKY: assert property (takenNxt && mask_r[0] && !wrMask ##1 !wrStatus && !wrMask |-> irq ##1 irq)
    else $error("interrupt not held");

  COV_ALWAYS: cover property (legal && isAlways && !trapEnable ##1 transferTaken);
  COV_COND_ANNUL: cover property (legal && !isUncond && !condTrue && annulBit ##1 annulSlot);
  COV_XTRAP: cover property (xtrapNxt ##1 transferTrap);
  COV_ILLEGAL: cover property (illegalNxt ##1 illegalTrap);
endmodule

// ### testbench/pfbu_fetch_model.sv
// Fetch stage model that presents one instruction per request
`timescale 1ns/10ps
module pfbu_fetch_model (
  input wire logic ref_clk, // Core clock
  input wire logic sendReq, // Present an instruction next cycle
  input wire logic [31:0] sendWord, // Instruction to present
  input wire pfbu_pkg::pfbu_addr_t sendPc, // Its address
  input wire logic [7:0] sendFlags, // Wide flags high, word flags low
  output logic instrValid, // Slot holds an instruction
  output logic [31:0] instrWord, // Instruction word
  output pfbu_pkg::pfbu_addr_t instrPc, // Instruction address
  output pfbu_pkg::pfbu_addr_t preNextPc, // Sequential next PC
  output logic [3:0] wordFlags, // Word flags
  output logic [3:0] wideFlags // Wide flags
);
  initial
  begin
    instrValid = 1'h0;
    instrWord = 32'h0;
    instrPc = 64'h0;
    preNextPc = 64'h4;
    {wideFlags, wordFlags} = 8'h0;
  end
  // Idle slots carry inverted junk so a stale word never looks fresh
  always @(posedge ref_clk)
  begin
    instrValid <= sendReq;
    instrWord <= sendReq ? sendWord : ~instrWord;
    instrPc <= sendReq ? sendPc : ~instrPc;
    preNextPc <= sendReq ? sendPc + 64'h4 : ~preNextPc;
    {wideFlags, wordFlags} <= sendReq ? sendFlags : ~{wideFlags, wordFlags};
  end
endmodule

// ### testbench/pfbu_branch_unit_tb_top.sv
// Self-checking bench for the predicted flag branch unit
`timescale 1ns/10ps
`include "pfbu_defs.svh"
module pfbu_branch_unit_tb_top;
  logic ref_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sendReq = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, instrWord, sendWord = 32'h0, rnd, rdv;
  logic [3:0] pstrb = 4'hF, wordFlags, wideFlags;
  logic [7:0] sendFlags = 8'h0;
  logic pready, pslverr, irq, instrValid, resolveValid, transferTaken, annulSlot, illegalTrap, transferTrap;
  logic prefetchValid, predictTaken, err;
  pfbu_pkg::pfbu_addr_t instrPc, preNextPc, targetPc, prefetchPc, sendPc = 64'h0, pc;
  int num_errors = 0, cmp_count = 0, nBr = 0;
  integer seed = 32'h1A04;
  pfbu_branch_unit uut (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .instrValid(instrValid), .instrWord(instrWord), .instrPc(instrPc), .preNextPc(preNextPc),
    .wordFlags(wordFlags), .wideFlags(wideFlags), .resolveValid(resolveValid), .transferTaken(transferTaken),
    .targetPc(targetPc), .annulSlot(annulSlot), .illegalTrap(illegalTrap), .transferTrap(transferTrap),
    .prefetchValid(prefetchValid), .prefetchPc(prefetchPc), .predictTaken(predictTaken));
  pfbu_fetch_model fetch (.ref_clk(ref_clk), .sendReq(sendReq), .sendWord(sendWord), .sendPc(sendPc),
    .sendFlags(sendFlags), .instrValid(instrValid), .instrWord(instrWord), .instrPc(instrPc),
    .preNextPc(preNextPc), .wordFlags(wordFlags), .wideFlags(wideFlags));
  always #20 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_out(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD register %h expected %h seen %h", a, exp, got);
    end
  endtask
  // One APB transfer; held until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n == 50)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rdv, err);
  endtask
  task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0, rdv, err);
    chk_reg(a, exp, rdv);
  endtask
  // Reference condition test on flags {N,Z,V,C}
  function automatic logic evalc(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'h0;
      3'h1: r = f[2];
      3'h2: r = f[2] | (f[3] ^ f[1]);
      3'h3: r = f[3] ^ f[1];
      3'h4: r = f[0] | f[2];
      3'h5: r = f[0];
      3'h6: r = f[3];
      default: r = f[1];
    endcase
    return c[3] ^ r;
  endfunction
  // Send one word through the fetch model and compare the outcome one cycle later
  task automatic issue(input logic [31:0] w, input logic [63:0] p, input logic [7:0] fl, input logic tte);
    logic t, u, ill, rec;
    @(posedge ref_clk);
    sendReq <= 1'h1;
    sendWord <= w;
    sendPc <= p;
    sendFlags <= fl;
    @(posedge ref_clk);
    sendReq <= 1'h0;
    @(posedge ref_clk);
    #1;
    rec = w[31:30] == 2'h0 && w[24:22] == 3'h1;
    t = evalc(w[28:25], w[21] ? fl[7:4] : fl[3:0]);
    u = w[27:25] == 3'h0;
    ill = w[20];
    nBr += rec;
    chk_out("resolveValid", rec, resolveValid);
    if (rec)
    begin
      chk_out("illegalTrap", ill, illegalTrap);
      chk_out("transferTaken", !ill && t && !tte, transferTaken);
      chk_out("transferTrap", !ill && t && tte, transferTrap);
      chk_out("annulSlot", !ill && !(t && tte) && w[29] && (u || !t), annulSlot);
      chk_out("prefetchValid", !ill && w[28:25] == 4'h0, prefetchValid);
      chk_out("targetPc", p + {{43{w[18]}}, w[18:0], 2'h0}, targetPc);
      chk_out("prefetchPc", p + {{43{w[18]}}, w[18:0], 2'h0}, prefetchPc);
      chk_out("predictTaken", !ill && w[19], predictTaken);
    end
  endtask
  initial
  begin
    #(40 * 20000);
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    // Reset values and an unmapped offset
    rreg(`PFBU_OFF_CTRL, 32'h0);
    rreg(`PFBU_OFF_MASK, 32'h0);
    rreg(`PFBU_OFF_LAST, 32'h10);
    apb(1'h0, 32'h24, 32'h0, rdv, err);
    chk_out("pslverr", 1'h1, err);
    $display("Test registers done");
    // Every selector with random flags, code select, annul and hint, trap off then on
    for (int i = 0; i < 384; i++)
    begin
      if (i == 256)
        wreg(`PFBU_OFF_CTRL, 32'h31);
      rnd = $random(seed);
      pc = {$random(seed), $random(seed)} & ~64'h3;
      issue({2'h0, rnd[0], i[3:0], 3'h1, rnd[3:1], rnd[22:4]}, pc, rnd[31:24], i >= 256);
    end
    issue({2'h1, rnd[29:0]}, pc, 8'h0, 1'h1);
    issue({2'h0, rnd[29:25], 3'h2, rnd[21:0]}, pc, 8'h0, 1'h1);
    $display("Test selectors done");
    // Transfer trap saves branch PC and pre-branch next PC at depth 3
    issue({2'h0, 1'h1, 4'h8, 3'h1, 3'h1, 19'h7FFFF}, 64'h123456789ABCDEF0, 8'h0, 1'h1);
    rreg(`PFBU_OFF_SPC_LO, 32'h9ABCDEF0);
    rreg(`PFBU_OFF_SPC_HI, 32'h12345678);
    rreg(`PFBU_OFF_SNPC_LO, 32'h9ABCDEF4);
    rreg(`PFBU_OFF_SNPC_HI, 32'h12345678);
    rreg(`PFBU_OFF_LAST, 32'h14);
    issue({2'h0, 1'h0, 4'h0, 3'h1, 3'h1, 19'h00010}, 64'h1000, 8'h0, 1'h1);
    $display("Test transfer trap done");
    // Sticky status, mask and level interrupt
    wreg(`PFBU_OFF_CTRL, 32'h0);
    wreg(`PFBU_OFF_STATUS, 32'hF);
    issue({2'h0, 1'h0, 4'h8, 3'h1, 3'h1, 19'h00004}, 64'h2000, 8'h0, 1'h0);
    rreg(`PFBU_OFF_STATUS, 32'h1);
    chk_out("irq", 1'h0, irq);
    wreg(`PFBU_OFF_MASK, 32'h1);
    // Let the write edge settle before looking at the level output
    #1;
    chk_out("irq", 1'h1, irq);
    wreg(`PFBU_OFF_STATUS, 32'h1);
    #1;
    chk_out("irq", 1'h0, irq);
    rreg(`PFBU_OFF_STATUS, 32'h0);
    rreg(`PFBU_OFF_COUNT, nBr);
    $display("Test interrupt done");
    stop_test();
  end
endmodule
